//--- sll_pkg.sv
// Shared constants and types for the segment latch loader
package sll_pkg;
  localparam int SEG_PINS = 40;
  localparam int COM_PINS = 6;
  localparam int PINS = SEG_PINS + COM_PINS;
  localparam int PHASES = 6;
  localparam int GROUPS = 32;
  localparam int PAT_W = 8;
  localparam int LINE_W = 3;
  localparam int STB_W = 5;
  localparam int MAP_W = LINE_W + STB_W;
  localparam int MODE_W = 4;
  localparam int STATIC_PHASE = 0;
  localparam int SEG_F_BIT = 5;
  localparam logic [6:0] WORK_REG_BASE = 7'h70;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [3:0] NIBBLE_MAX_DIGIT = 4'h9;
  localparam logic [3:0] NIBBLE_SEVEN = 4'h7;
  localparam logic [PAT_W-1:0] PAT_BLANK = 8'h00;
  localparam logic [GROUPS-1:0] ONE_GROUP = 32'h0000_0001;
  localparam logic [GROUPS-1:0] BANK0_MASK = 32'h0000_FFFF;
  localparam logic [GROUPS-1:0] BANK1_MASK = 32'hFFFF_0000;
  localparam logic [GROUPS-1:0] NO_GROUP = 32'h0000_0000;
  localparam logic DISPLAY_ON_RST = 1'b1;
  // Pin configuration field: 0 CMOS static, 10 open-drain static, 1..6 multiplexed
  localparam logic [MODE_W-1:0] MODE_CMOS = 4'h0;
  localparam logic [MODE_W-1:0] MODE_LCD = 4'h1;
  localparam logic [MODE_W-1:0] MODE_OPEN_DRAIN = 4'hA;
  // Digit patterns, bit 0 is line A, bit 7 is line H; F of digit 7 is optional
  localparam logic [9:0][PAT_W-1:0] DIGIT_PAT = {
    8'hEF, 8'hFF, 8'h87, 8'hFD, 8'hED, 8'hE6, 8'hCF, 8'hDB, 8'h86, 8'hBF};

  typedef enum logic [3:0] {
    SLL_OP_IDLE,
    SLL_OP_DECODE_WRITE,
    SLL_OP_DECODE_BLANK_WRITE,
    SLL_OP_RAW_NIBBLE_WRITE,
    SLL_OP_TABLE_BYTE_WRITE,
    SLL_OP_DECODE_WRITE_PTR,
    SLL_OP_DECODE_BLANK_WRITE_PTR,
    SLL_OP_RAW_NIBBLE_WRITE_PTR,
    SLL_OP_BANK_TABLE_WRITE,
    SLL_OP_BANK_DECODE_WRITE,
    SLL_OP_BANK_DECODE_BLANK_WRITE,
    SLL_OP_BANK_RAW_WRITE
  } sll_op_e;

  typedef enum logic [1:0] {
    SLL_SRC_DECODE,
    SLL_SRC_BLANK,
    SLL_SRC_RAW,
    SLL_SRC_TABLE
  } sll_src_e;

  // Default routing: latch n takes line n mod 8 and strobe (n / 8) mod 32
  function automatic logic [PINS*PHASES*MAP_W-1:0] sll_default_map();
    logic [PINS*PHASES*MAP_W-1:0] m;
    m = '0;
    for (int i = 0; i < PINS * PHASES; i++) begin
      m[i*MAP_W +: MAP_W] = MAP_W'(i);
    end
    return m;
  endfunction
endpackage

//--- sll_wr_if.sv
// Pattern bus and latch strobes shared by all latch cells
`timescale 1ns/1ps
interface sll_wr_if;
  logic [sll_pkg::PAT_W-1:0] segment_pattern_bus;
  logic [sll_pkg::GROUPS-1:0] latch_group_strobe;
  modport src (output segment_pattern_bus, output latch_group_strobe);
  modport dst (input segment_pattern_bus, input latch_group_strobe);
endinterface

//--- sll_digit_decoder.sv
// Nibble to seven-segment digit decoder with leading-zero blanking
`timescale 1ns/1ps
module sll_digit_decoder #(
  parameter logic SEVEN_F_ON = 1'b1
) (
  input wire logic [3:0] nibble,
  input wire logic blank_zero,
  output logic [sll_pkg::PAT_W-1:0] pattern
);
  always_comb begin
    if (nibble > sll_pkg::NIBBLE_MAX_DIGIT) begin
      pattern = sll_pkg::PAT_BLANK; // RL17
    end else if (blank_zero && nibble == sll_pkg::NIBBLE_ZERO) begin
      pattern = sll_pkg::PAT_BLANK; // RL7 RL11
    end else begin
      pattern = sll_pkg::DIGIT_PAT[nibble]; // RL17
      if (nibble == sll_pkg::NIBBLE_SEVEN) begin
        pattern[sll_pkg::SEG_F_BIT] = SEVEN_F_ON; // RL17
      end
    end
  end
endmodule // sll_digit_decoder

//--- sll_latch_cell.sv
// The per-phase storage latches of one output pin
`timescale 1ns/1ps
module sll_latch_cell #(
  parameter logic [sll_pkg::PHASES*sll_pkg::MAP_W-1:0] MAP = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  sll_wr_if.dst wr,
  output logic [sll_pkg::PHASES-1:0] latch_q
);
  for (genvar j = 0; j < sll_pkg::PHASES; j++) begin : g_phase
    localparam logic [sll_pkg::LINE_W-1:0] LN = MAP[j*sll_pkg::MAP_W +: sll_pkg::LINE_W];
    localparam logic [sll_pkg::STB_W-1:0] SB =
      MAP[j*sll_pkg::MAP_W+sll_pkg::LINE_W +: sll_pkg::STB_W];

    logic q_ff;

    // One routed line into one routed strobe, per common phase
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        q_ff <= 1'b0;
      end else if (clk_en && wr.latch_group_strobe[SB]) begin
        q_ff <= wr.segment_pattern_bus[LN]; // RL1 RL2
      end
    end
    assign latch_q[j] = q_ff;

    latch_take_a: assert property (@(posedge clk) disable iff (sys_rst) // RL2
      clk_en && wr.latch_group_strobe[SB] |=> latch_q[j] == $past(wr.segment_pattern_bus[LN]))
      else $error("Latch missed its routed bus line");
    latch_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RL18
      !(clk_en && wr.latch_group_strobe[SB]) |=> $stable(latch_q[j]))
      else $error("Latch changed without its strobe");
  end
endmodule // sll_latch_cell

//--- sll_segment_latch_loader.sv
// Segment latch loader: builds the pattern bus and drives the latch array
//
// Overview of operation
// (RL1) Six phase latches behind every segment output
// (RL2) Latch data and strobe chosen by routing
// (RL3) Bank writes strobe sixteen groups, halves by operand
// (RL4) Single writes address one of 32 groups
// (RL5) Working register nibble sits at index plus 70h
// (RL6) Register decode write stores decoded digit pattern
// (RL7) Register blanking write turns zero into blank
// (RL8) Register raw write: nibble low, accumulator high
// (RL9) Table write puts ROM byte straight on bus
// (RL10) Pointer decode write stores decoded pointed nibble
// (RL11) Pointer blanking write blanks a zero nibble
// (RL12) Pointer raw write: pointed nibble plus accumulator
// (RL13) Bank table write loads one byte into all sixteen groups of a half
// (RL14) Bank decode and raw writes use pointer
// (RL15) Pin field: phase 1-6, 0 CMOS, 10 open-drain
// (RL16) Pins are 40 segments plus six commons
// (RL17) Decoder shows 0-9, blanks A-F, optional F
// (RL18) Blank and restore leave latch contents alone
// (RL19) Stop state drives every output to ground; open-drain pins are released instead (static_oe low, static_out high)
// (RL20) Whole bank updates in one instruction cycle
// (RL21) Core holds operands steady during the strobe
`timescale 1ns/1ps
module sll_segment_latch_loader #(
  parameter logic SEVEN_F_ON = 1'b1,
  parameter logic [sll_pkg::PINS*sll_pkg::PHASES*sll_pkg::MAP_W-1:0] PLA_MAP =
    sll_pkg::sll_default_map(),
  parameter logic [sll_pkg::PINS*sll_pkg::MODE_W-1:0] PIN_MODE =
    {{sll_pkg::COM_PINS{sll_pkg::MODE_CMOS}}, {sll_pkg::SEG_PINS{sll_pkg::MODE_LCD}}}
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire sll_pkg::sll_op_e op,
  input wire logic [4:0] latch_group_addr,
  input wire logic bank_sel,
  input wire logic [3:0] work_reg_index,
  input wire logic [6:0] index_pointer,
  input wire logic [3:0] ram_nibble,
  input wire logic [3:0] accumulator,
  input wire logic [7:0] table_rom_byte,
  input wire logic display_blank_cmd,
  input wire logic display_restore_cmd,
  input wire logic stop_state,
  output logic [6:0] ram_rd_addr,
  output logic [sll_pkg::PAT_W-1:0] segment_pattern_bus,
  output logic display_active,
  output logic [sll_pkg::SEG_PINS*sll_pkg::PHASES-1:0] lcd_phase_data,
  output logic [sll_pkg::PINS-1:0] static_out,
  output logic [sll_pkg::PINS-1:0] static_oe
);
  sll_wr_if wr ();

  logic wr_req;
  logic is_bank;
  logic is_ptr;
  sll_pkg::sll_src_e src;
  logic [sll_pkg::PAT_W-1:0] dec_pat;
  logic [sll_pkg::PAT_W-1:0] pattern;
  logic [sll_pkg::GROUPS-1:0] strobe;
  logic display_on_ff;
  logic nxt_display_on;
  logic drive_on;
  logic [sll_pkg::PAT_W-1:0] pattern_ff;
  logic active_ff;
  logic [sll_pkg::SEG_PINS*sll_pkg::PHASES-1:0] lcd_ff;
  logic [sll_pkg::SEG_PINS*sll_pkg::PHASES-1:0] nxt_lcd;
  logic [sll_pkg::SEG_PINS*sll_pkg::PHASES-1:0] seg_latch;
  logic [sll_pkg::PINS-1:0] static_out_ff;
  logic [sll_pkg::PINS-1:0] static_oe_ff;
  logic [sll_pkg::PINS-1:0] nxt_static_out;
  logic [sll_pkg::PINS-1:0] nxt_static_oe;
  logic [sll_pkg::PHASES-1:0] pin_latch [sll_pkg::PINS];

  // Instruction decode into source, operand kind and strobe width
  always_comb begin
    wr_req = 1'b1;
    is_bank = 1'b0;
    is_ptr = 1'b0;
    src = sll_pkg::SLL_SRC_DECODE;
    unique case (op)
      sll_pkg::SLL_OP_IDLE: wr_req = 1'b0;
      sll_pkg::SLL_OP_DECODE_WRITE: src = sll_pkg::SLL_SRC_DECODE; // RL6
      sll_pkg::SLL_OP_DECODE_BLANK_WRITE: src = sll_pkg::SLL_SRC_BLANK; // RL7
      sll_pkg::SLL_OP_RAW_NIBBLE_WRITE: src = sll_pkg::SLL_SRC_RAW; // RL8
      sll_pkg::SLL_OP_TABLE_BYTE_WRITE: src = sll_pkg::SLL_SRC_TABLE; // RL9
      sll_pkg::SLL_OP_DECODE_WRITE_PTR: begin
        src = sll_pkg::SLL_SRC_DECODE; // RL10
        is_ptr = 1'b1;
      end
      sll_pkg::SLL_OP_DECODE_BLANK_WRITE_PTR: begin
        src = sll_pkg::SLL_SRC_BLANK; // RL11
        is_ptr = 1'b1;
      end
      sll_pkg::SLL_OP_RAW_NIBBLE_WRITE_PTR: begin
        src = sll_pkg::SLL_SRC_RAW; // RL12
        is_ptr = 1'b1;
      end
      sll_pkg::SLL_OP_BANK_TABLE_WRITE: begin
        src = sll_pkg::SLL_SRC_TABLE; // RL13
        is_bank = 1'b1;
      end
      sll_pkg::SLL_OP_BANK_DECODE_WRITE: begin
        src = sll_pkg::SLL_SRC_DECODE; // RL14
        is_bank = 1'b1;
        is_ptr = 1'b1;
      end
      sll_pkg::SLL_OP_BANK_DECODE_BLANK_WRITE: begin
        src = sll_pkg::SLL_SRC_BLANK; // RL14
        is_bank = 1'b1;
        is_ptr = 1'b1;
      end
      sll_pkg::SLL_OP_BANK_RAW_WRITE: begin
        src = sll_pkg::SLL_SRC_RAW; // RL14
        is_bank = 1'b1;
        is_ptr = 1'b1;
      end
      // Unused op codes are dropped rather than guessed at
      default: wr_req = 1'b0;
    endcase
  end

  // Core returns the nibble at this address in the same cycle
  // A pointer operand bypasses the working register window
  assign ram_rd_addr = is_ptr ? index_pointer
                              : 7'(sll_pkg::WORK_REG_BASE + {3'h0, work_reg_index}); // RL5

  sll_digit_decoder #(.SEVEN_F_ON(SEVEN_F_ON)) u_decoder (
    .nibble(ram_nibble),
    .blank_zero(src == sll_pkg::SLL_SRC_BLANK),
    .pattern(dec_pat)
  );

  always_comb begin
    unique case (src)
      sll_pkg::SLL_SRC_DECODE: pattern = dec_pat; // RL6 RL10
      sll_pkg::SLL_SRC_BLANK: pattern = dec_pat; // RL7 RL11
      sll_pkg::SLL_SRC_RAW: pattern = {accumulator, ram_nibble}; // RL8 RL12
      sll_pkg::SLL_SRC_TABLE: pattern = table_rom_byte; // RL9 RL13
    endcase
  end

  // Bank writes strobe the whole half at once, so no partial bank is ever shown
  always_comb begin
    if (!wr_req) begin
      strobe = sll_pkg::NO_GROUP;
    end else if (is_bank) begin
      strobe = bank_sel ? sll_pkg::BANK1_MASK : sll_pkg::BANK0_MASK; // RL3 RL20
    end else begin
      strobe = sll_pkg::ONE_GROUP << latch_group_addr; // RL4
    end
  end

  assign wr.segment_pattern_bus = pattern;
  assign wr.latch_group_strobe = strobe; // RL21

  for (genvar p = 0; p < sll_pkg::PINS; p++) begin : g_pin
    sll_latch_cell #(
      .MAP(PLA_MAP[p*sll_pkg::PHASES*sll_pkg::MAP_W +: sll_pkg::PHASES*sll_pkg::MAP_W])
    ) u_cell (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .wr(wr),
      .latch_q(pin_latch[p])
    ); // RL1 RL2 RL16
  end

  // Restore wins when both commands arrive together
  assign nxt_display_on = display_restore_cmd ? 1'b1 :
                          display_blank_cmd ? 1'b0 : display_on_ff; // RL18
  assign drive_on = nxt_display_on && !stop_state; // RL19

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      display_on_ff <= sll_pkg::DISPLAY_ON_RST;
    end else if (clk_en) begin
      display_on_ff <= nxt_display_on; // RL18
    end
  end

  // Last written pattern stays until the next write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pattern_ff <= sll_pkg::PAT_BLANK;
    end else if (clk_en && wr_req) begin
      pattern_ff <= pattern;
    end
  end

  // Output drive follows the pin field; blanking never touches the latches
  always_comb begin
    logic [sll_pkg::MODE_W-1:0] mode;
    mode = sll_pkg::MODE_LCD;
    nxt_lcd = '0;
    seg_latch = '0;
    nxt_static_out = '0;
    nxt_static_oe = '0;
    for (int p = 0; p < sll_pkg::PINS; p++) begin
      mode = PIN_MODE[p*sll_pkg::MODE_W +: sll_pkg::MODE_W];
      if (p < sll_pkg::SEG_PINS) begin
        seg_latch[p*sll_pkg::PHASES +: sll_pkg::PHASES] = pin_latch[p];
        if (mode != sll_pkg::MODE_CMOS && mode != sll_pkg::MODE_OPEN_DRAIN && drive_on) begin
          nxt_lcd[p*sll_pkg::PHASES +: sll_pkg::PHASES] =
            seg_latch[p*sll_pkg::PHASES +: sll_pkg::PHASES]; // RL15 RL18
        end
      end
      if (mode == sll_pkg::MODE_CMOS) begin
        nxt_static_oe[p] = 1'b1; // RL15
        nxt_static_out[p] = drive_on && pin_latch[p][sll_pkg::STATIC_PHASE]; // RL19
      end else if (mode == sll_pkg::MODE_OPEN_DRAIN) begin
        nxt_static_out[p] = 1'b1;
        nxt_static_oe[p] = drive_on && pin_latch[p][sll_pkg::STATIC_PHASE]; // RL15 RL19
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lcd_ff <= '0;
      static_out_ff <= '0;
      static_oe_ff <= '0;
      active_ff <= 1'b0;
    end else if (clk_en) begin
      lcd_ff <= nxt_lcd;
      static_out_ff <= nxt_static_out;
      static_oe_ff <= nxt_static_oe;
      active_ff <= drive_on; // RL19
    end
  end

  assign segment_pattern_bus = pattern_ff;
  assign display_active = active_ff;
  assign lcd_phase_data = lcd_ff;
  assign static_out = static_out_ff;
  assign static_oe = static_oe_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Combinational paths are checked at the edge that would latch them

  sequence s_blank;
    clk_en && display_blank_cmd && !display_restore_cmd;
  endsequence
  sequence s_restore;
    clk_en && display_restore_cmd && !stop_state;
  endsequence

  single_strobe_a: assert property (wr_req && !is_bank |-> // RL4
    $onehot(strobe) && strobe[latch_group_addr])
    else $error("Single write did not strobe exactly its group");
  bank_strobe_a: assert property (wr_req && is_bank |-> // RL3
    $countones(strobe) == 16 && strobe[{bank_sel, 4'h0}] && strobe[{bank_sel, 4'hF}])
    else $error("Bank write strobed the wrong groups");
  work_reg_a: assert property (wr_req && !is_ptr |-> // RL5
    ram_rd_addr[6:4] == 3'h7 && ram_rd_addr[3:0] == work_reg_index)
    else $error("Working register address wrong");
  blank_zero_a: assert property (src == sll_pkg::SLL_SRC_BLANK && // RL7
    ram_nibble == 4'h0 |-> pattern == 8'h00)
    else $error("Blanking write drove a zero digit");
  raw_map_a: assert property (wr_req && src == sll_pkg::SLL_SRC_RAW |-> // RL8
    pattern[3:0] == ram_nibble && pattern[7:4] == accumulator)
    else $error("Raw write mapped lines wrongly");
  table_map_a: assert property (wr_req && src == sll_pkg::SLL_SRC_TABLE |-> // RL9
    pattern == table_rom_byte)
    else $error("Table write altered the ROM byte");
  bus_record_a: assert property (clk_en && wr_req |=> // RL6
    segment_pattern_bus == $past(pattern))
    else $error("Pattern bus record lags the write");
  display_off_a: assert property (s_blank |=> lcd_phase_data == '0 ##1 // RL18
    (!$past(clk_en) || $past(display_restore_cmd) || lcd_phase_data == '0))
    else $error("Blanked display still drives segments");
  restore_a: assert property (s_restore |=> // RL18
    lcd_phase_data == ($past(nxt_lcd)) && display_active)
    else $error("Restore did not show stored patterns");
  stop_ground_a: assert property (clk_en && stop_state |=> // RL19
    lcd_phase_data == '0 && (static_out & static_oe) == '0 && !display_active)
    else $error("Outputs not grounded in stop state");
  hex_blank_a: assert property (wr_req && ram_nibble > sll_pkg::NIBBLE_MAX_DIGIT && // RL17
    (src == sll_pkg::SLL_SRC_DECODE || src == sll_pkg::SLL_SRC_BLANK) |->
    pattern == sll_pkg::PAT_BLANK)
    else $error("Nibble above nine lit a segment");
  decode_pat_a: assert property (wr_req && src == sll_pkg::SLL_SRC_DECODE && // RL17
    ram_nibble <= sll_pkg::NIBBLE_MAX_DIGIT && ram_nibble != sll_pkg::NIBBLE_SEVEN |->
    pattern == sll_pkg::DIGIT_PAT[ram_nibble])
    else $error("Decoded digit pattern wrong");
  ptr_addr_a: assert property (wr_req && is_ptr |-> // RL10
    ram_rd_addr == index_pointer)
    else $error("Pointer operand not sent to data memory");
  idle_strobe_a: assert property (!wr_req |-> // RL4
    strobe == sll_pkg::NO_GROUP)
    else $error("Strobe raised with no write");
  freeze_a: assert property (!clk_en |=> $stable(segment_pattern_bus) && // RL2
    $stable(lcd_phase_data) && $stable(display_active) && $stable(static_out))
    else $error("Outputs moved while clock enable was low");
  bus_hold_a: assert property (clk_en && !wr_req |=> // RL6
    $stable(segment_pattern_bus))
    else $error("Pattern record changed without a write");
  blank_active_a: assert property (s_blank |=> // RL18
    !display_active)
    else $error("Display still active after blanking");
endmodule // sll_segment_latch_loader

//--- sll_core_model.sv
// Core-side model: data RAM and table ROM answering the loader
`timescale 1ns/1ps
module sll_core_model (
  input wire logic [6:0] ram_rd_addr,
  input wire logic [6:0] index_pointer,
  output logic [3:0] ram_nibble,
  output logic [7:0] table_rom_byte
);
  logic [3:0] mem [128];
  logic [7:0] rom [128];
  // Same-cycle answers; unwritten cells stay unknown so stray reads show up
  assign ram_nibble = mem[ram_rd_addr];
  assign table_rom_byte = rom[index_pointer];
endmodule // sll_core_model

//--- tb_sll_segment_latch_loader.sv
// Self-checking bench for the segment latch loader
`timescale 1ns/1ps
module tb_sll_segment_latch_loader;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  sll_pkg::sll_op_e op = sll_pkg::SLL_OP_IDLE;
  logic [4:0] latch_group_addr = 5'h00;
  logic bank_sel = 1'b0;
  logic [3:0] work_reg_index = 4'h0;
  logic [6:0] index_pointer = 7'h00;
  logic [3:0] ram_nibble;
  logic [3:0] accumulator = 4'h0;
  logic [7:0] table_rom_byte;
  logic display_blank_cmd = 1'b0;
  logic display_restore_cmd = 1'b0;
  logic stop_state = 1'b0;
  logic [6:0] ram_rd_addr;
  logic [7:0] segment_pattern_bus;
  logic display_active;
  logic [sll_pkg::SEG_PINS*sll_pkg::PHASES-1:0] lcd_phase_data;
  logic [sll_pkg::PINS-1:0] static_out;
  logic [sll_pkg::PINS-1:0] static_oe;
  // Expected digit patterns, F segment of seven on
  logic [7:0] dig_tab [16] = '{8'hBF, 8'h86, 8'hDB, 8'hCF, 8'hE6, 8'hED, 8'hFD, 8'hA7,
    8'hFF, 8'hEF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] shadow [32];
  logic [7:0] last_bus = 8'h00;
  logic shown = 1'b1;
  int err_total = 0;
  int n_tests = 0;

  always #25 clk = ~clk;

  sll_segment_latch_loader uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .op(op),
    .latch_group_addr(latch_group_addr), .bank_sel(bank_sel),
    .work_reg_index(work_reg_index), .index_pointer(index_pointer),
    .ram_nibble(ram_nibble), .accumulator(accumulator), .table_rom_byte(table_rom_byte),
    .display_blank_cmd(display_blank_cmd), .display_restore_cmd(display_restore_cmd),
    .stop_state(stop_state), .ram_rd_addr(ram_rd_addr),
    .segment_pattern_bus(segment_pattern_bus), .display_active(display_active),
    .lcd_phase_data(lcd_phase_data), .static_out(static_out), .static_oe(static_oe));

  sll_core_model core (.ram_rd_addr(ram_rd_addr), .index_pointer(index_pointer),
    .ram_nibble(ram_nibble), .table_rom_byte(table_rom_byte));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Default routing puts group g on phase bits g*8..g*8+7 for groups 0..29
  task automatic chk_all();
    int n;
    for (int g = 0; g < 30; g++) begin
      check(lcd_phase_data[g*8 +: 8], shown ? shadow[g] : 8'h00);
    end
    // Commons are CMOS static pins fed from their phase-0 latch
    for (int c = 0; c < 6; c++) begin
      n = (40 + c) * 6;
      check(static_out[40 + c], shown && shadow[(n / 8) % 32][n % 8]);
    end
    check(static_oe, {6'h3F, 40'h0});
  endtask

  task automatic wr(input sll_pkg::sll_op_e o, input logic [4:0] a, input logic b,
      input logic [3:0] ix, input logic [6:0] p, input logic [3:0] ac, input logic [7:0] e);
    op = o;
    latch_group_addr = a;
    bank_sel = b;
    work_reg_index = ix;
    index_pointer = p;
    accumulator = ac;
    @(posedge clk);
    #1;
    op = sll_pkg::SLL_OP_IDLE;
    check(segment_pattern_bus, e);
    last_bus = e;
    if (o >= sll_pkg::SLL_OP_BANK_TABLE_WRITE) begin
      for (int g = 0; g < 16; g++) begin
        shadow[{b, 4'(g)}] = e;
      end
    end else begin
      shadow[a] = e;
    end
    tick();
    chk_all();
  endtask

  task automatic reset_state();
    tick();
    check(display_active, 1'b1);
    check(segment_pattern_bus, 8'h00);
    chk_all();
  endtask

  task automatic decode_all();
    for (int v = 0; v < 16; v++) begin
      core.mem[7'h70 + 7'(15 - v)] = 4'(v);
      wr(sll_pkg::SLL_OP_DECODE_WRITE, 5'(v), 1'b0, 4'(15 - v), 7'h00, 4'h0, dig_tab[v]);
      check(ram_rd_addr, 7'h70 + 7'(15 - v));
    end
  endtask

  // Register and pointer sources hold different nibbles to catch a swapped source
  task automatic single_ops();
    sll_pkg::sll_op_e ops [6] = '{sll_pkg::SLL_OP_DECODE_WRITE,
      sll_pkg::SLL_OP_DECODE_BLANK_WRITE, sll_pkg::SLL_OP_RAW_NIBBLE_WRITE,
      sll_pkg::SLL_OP_DECODE_WRITE_PTR, sll_pkg::SLL_OP_DECODE_BLANK_WRITE_PTR,
      sll_pkg::SLL_OP_RAW_NIBBLE_WRITE_PTR};
    logic [3:0] vals [3] = '{4'h0, 4'h7, 4'hC};
    logic [3:0] v;
    logic [7:0] e;
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 3; j++) begin
        v = vals[j];
        core.mem[7'h73] = (k < 3) ? v : v ^ 4'h5;
        core.mem[7'h1F] = (k < 3) ? v ^ 4'h5 : v;
        case (k % 3)
          0: e = dig_tab[v];
          1: e = (v == 4'h0) ? 8'h00 : dig_tab[v];
          default: e = {4'h9, v};
        endcase
        wr(ops[k], 5'(16 + k), 1'b0, 4'h3, 7'h1F, 4'h9, e);
      end
    end
  endtask

  task automatic table_ops();
    core.rom[7'h2A] = 8'h3C;
    wr(sll_pkg::SLL_OP_TABLE_BYTE_WRITE, 5'h1F, 1'b0, 4'h0, 7'h2A, 4'h0, 8'h3C);
    core.rom[7'h2B] = 8'hC3;
    wr(sll_pkg::SLL_OP_TABLE_BYTE_WRITE, 5'h1D, 1'b0, 4'h0, 7'h2B, 4'h0, 8'hC3);
  endtask

  task automatic bank_ops();
    logic [3:0] n;
    logic [7:0] t;
    for (int b = 0; b < 2; b++) begin
      n = (b == 1) ? 4'h2 : 4'h0;
      t = (b == 1) ? 8'hA5 : 8'h5A;
      core.mem[7'h40] = n;
      core.rom[7'h40] = t;
      wr(sll_pkg::SLL_OP_BANK_TABLE_WRITE, 5'h07, 1'(b), 4'h0, 7'h40, 4'h6, t);
      wr(sll_pkg::SLL_OP_BANK_DECODE_WRITE, 5'h07, 1'(b), 4'h0, 7'h40, 4'h6, dig_tab[n]);
      wr(sll_pkg::SLL_OP_BANK_DECODE_BLANK_WRITE, 5'h07, 1'(b), 4'h0, 7'h40, 4'h6,
        (n == 4'h0) ? 8'h00 : dig_tab[n]);
      wr(sll_pkg::SLL_OP_BANK_RAW_WRITE, 5'h07, 1'(b), 4'h0, 7'h40, 4'h6, {4'h6, n});
    end
  endtask

  task automatic blank_restore();
    display_blank_cmd = 1'b1;
    tick();
    display_blank_cmd = 1'b0;
    shown = 1'b0;
    check(display_active, 1'b0);
    core.mem[7'h75] = 4'h8;
    wr(sll_pkg::SLL_OP_DECODE_WRITE, 5'h02, 1'b0, 4'h5, 7'h00, 4'h0, 8'hFF);
    display_blank_cmd = 1'b1;
    display_restore_cmd = 1'b1;
    tick();
    display_blank_cmd = 1'b0;
    display_restore_cmd = 1'b0;
    shown = 1'b1;
    check(display_active, 1'b1);
    chk_all();
  endtask

  task automatic stop_check();
    stop_state = 1'b1;
    tick();
    shown = 1'b0;
    check(display_active, 1'b0);
    check(static_out, 64'h0);
    chk_all();
    stop_state = 1'b0;
    tick();
    shown = 1'b1;
    check(display_active, 1'b1);
    chk_all();
  endtask

  // A frozen clock enable must drop the instruction entirely
  task automatic enable_freeze();
    clk_en = 1'b0;
    core.mem[7'h71] = 4'h1;
    op = sll_pkg::SLL_OP_DECODE_WRITE;
    latch_group_addr = 5'h00;
    work_reg_index = 4'h1;
    tick();
    op = sll_pkg::SLL_OP_IDLE;
    clk_en = 1'b1;
    tick();
    check(segment_pattern_bus, last_bus);
    chk_all();
  endtask

  // Reset in mid-run clears every latch and brings the display back on
  task automatic mid_reset();
    display_blank_cmd = 1'b1;
    tick();
    display_blank_cmd = 1'b0;
    sys_rst = 1'b1;
    tick();
    check(display_active, 1'b0);
    check(|lcd_phase_data, 1'b0);
    check(segment_pattern_bus, 8'h00);
    tick();
    sys_rst = 1'b0;
    for (int g = 0; g < 32; g++) begin
      shadow[g] = 8'h00;
    end
    last_bus = 8'h00;
    shown = 1'b1;
    tick();
    check(display_active, 1'b1);
    chk_all();
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    for (int g = 0; g < 32; g++) begin
      shadow[g] = 8'h00;
    end
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    reset_state();
    decode_all();
    single_ops();
    table_ops();
    bank_ops();
    blank_restore();
    stop_check();
    enable_freeze();
    mid_reset();
    tally_and_finish();
  end
endmodule // tb_sll_segment_latch_loader
